/* File: tw_device_port.sv */
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - host holds select high whole transaction
// - select high enables shifter and logic
// - select low aborts, releases data line
// - one clock cycle: rise then fall
// - inputs sampled on rising clock edge
// - read bits driven on falling edge
// - all bytes least significant bit first
// - first byte is command, data follows
// - command top bit: 0 read, 1 write
// - single access: one byte then deselect
// - pointer increments after every data byte
// - pointer wraps from 0Dh to 00h
// - low seven command bits give address
// - write protect bit blocks all writes
// - reserved addresses read zero, ignore writes
module tw_device_port
  import tw_pkg::*;
(
  tw_link_if.dev          link,
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  output logic [6:0]      reg_addr,
  output logic            reg_rd_stb,
  output logic            reg_wr_stb,
  output logic [7:0]      reg_wr_data,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       wp_bit
);
  // ==========================================================
  // link domain, cleared while deselected
  typedef enum logic [1:0] {PH_CMD, PH_READ, PH_WRITE} link_phase_t;
  link_phase_t phase_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [6:0]  ptr_reg;
  logic [7:0]  rd_buf_reg;
  logic        dq_o_reg;
  logic        dq_oe_reg;
  logic        ev_lvl_reg;
  logic        ev_wr_reg;
  logic [6:0]  ev_addr_reg;
  logic [7:0]  ev_data_reg;
  logic        rd_lvl_reg;
  logic        byte_end;
  logic        cmd_end;
  logic        data_end;
  logic        rd_load;
  logic [7:0]  in_byte;
  logic [7:0]  rd_value;

  assign byte_end = bit_cnt_reg == LAST_BIT;
  assign cmd_end  = byte_end && phase_reg == PH_CMD;
  assign data_end = byte_end && phase_reg != PH_CMD;
  assign in_byte  = {link.dq, shift_reg[7:1]};
  assign rd_load  = phase_reg == PH_READ && bit_cnt_reg == 3'h0;
  // reserved addresses read as zero
  assign rd_value = reg_reserved(ptr_reg) ? 8'h00 : reg_rd_data;

  // bit counter, one step per clock cycle
  always_ff @(posedge link.sclk or negedge link.sel) begin
    if (!link.sel) begin
      bit_cnt_reg <= 3'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // input shifter, sampled on the rising edge
  always_ff @(posedge link.sclk or negedge link.sel) begin
    if (!link.sel) begin
      shift_reg <= 8'h00;
    end else begin
      shift_reg <= in_byte;
    end
  end

  // phase: command first, then read or write
  always_ff @(posedge link.sclk or negedge link.sel) begin
    if (!link.sel) begin
      phase_reg <= PH_CMD;
    end else if (cmd_end) begin
      if (in_byte[CMD_DIR_BIT]) begin
        phase_reg <= PH_WRITE;
      end else begin
        phase_reg <= PH_READ;
      end
    end
  end

  // register pointer
  always_ff @(posedge link.sclk or negedge link.sel) begin
    if (!link.sel) begin
      ptr_reg <= ADDR_FIRST;
    end else if (cmd_end) begin
      ptr_reg <= in_byte[ADDR_W-1:0];
    end else if (data_end) begin
      ptr_reg <= next_addr(ptr_reg);
    end
  end

  // completed data byte, held for the system side
  always_ff @(posedge link.sclk or negedge link.sel) begin
    if (!link.sel) begin
      ev_wr_reg   <= 1'b0;
      ev_addr_reg <= ADDR_FIRST;
      ev_data_reg <= 8'h00;
    end else if (data_end) begin
      ev_wr_reg   <= phase_reg == PH_WRITE;
      ev_addr_reg <= ptr_reg;
      ev_data_reg <= in_byte;
    end
  end

  // byte done level, one link cycle long; select must stay high
  // a few system clocks after the last byte or its event is lost
  always_ff @(posedge link.sclk or negedge link.sel) begin
    if (!link.sel) begin
      ev_lvl_reg <= 1'b0;
    end else begin
      ev_lvl_reg <= data_end;
    end
  end

  // output shifter, moves on the falling edge
  always_ff @(negedge link.sclk or negedge link.sel) begin
    if (!link.sel) begin
      dq_oe_reg  <= 1'b0;
      dq_o_reg   <= 1'b0;
      rd_buf_reg <= 8'h00;
    end else if (phase_reg == PH_READ) begin
      dq_oe_reg <= 1'b1;
      if (rd_load) begin
        dq_o_reg   <= rd_value[0];
        rd_buf_reg <= {1'b0, rd_value[7:1]};
      end else begin
        dq_o_reg   <= rd_buf_reg[0];
        rd_buf_reg <= {1'b0, rd_buf_reg[7:1]};
      end
    end
  end

  // fetch level, one link cycle per byte loaded
  always_ff @(negedge link.sclk or negedge link.sel) begin
    if (!link.sel) begin
      rd_lvl_reg <= 1'b0;
    end else begin
      rd_lvl_reg <= rd_load;
    end
  end

  // write address stays with its byte, read address leads the shifter
  assign link.dev_dq_o  = dq_o_reg;
  assign link.dev_dq_oe = dq_oe_reg;
  assign reg_addr       = (phase_reg == PH_WRITE) ? ev_addr_reg : ptr_reg;

  // ==========================================================
  // system domain: level crossings of byte events
  logic [2:0] ev_sync_reg;
  logic [2:0] rf_sync_reg;
  logic [7:0] wr_data_reg;
  logic       wr_stb_reg;
  logic       rd_stb_reg;
  logic       ev_pulse;
  logic       rf_pulse;
  logic       wr_allow;

  // rising edge behind a two stage synchroniser
  function automatic logic rise_seen(input logic [2:0] s);
    return s[1] && !s[2];
  endfunction

  assign ev_pulse = rise_seen(ev_sync_reg);
  assign rf_pulse = rise_seen(rf_sync_reg);
  assign wr_allow = ev_wr_reg && !wp_bit && !reg_reserved(ev_addr_reg);

  // synchronisers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ev_sync_reg <= 3'h0;
      rf_sync_reg <= 3'h0;
    end else begin
      ev_sync_reg <= {ev_sync_reg[1:0], ev_lvl_reg};
      rf_sync_reg <= {rf_sync_reg[1:0], rd_lvl_reg};
    end
  end

  // write strobe and data
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_stb_reg  <= 1'b0;
      wr_data_reg <= 8'h00;
    end else begin
      wr_stb_reg <= ev_pulse && wr_allow;
      if (ev_pulse) begin
        wr_data_reg <= ev_data_reg;
      end
    end
  end

  // read fetch strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_stb_reg <= 1'b0;
    end else begin
      rd_stb_reg <= rf_pulse;
    end
  end

  assign reg_wr_stb  = wr_stb_reg;
  assign reg_wr_data = wr_data_reg;
  assign reg_rd_stb  = rd_stb_reg;
endmodule
`default_nettype wire

/* File: tw_pkg.sv */
package tw_pkg;
  // ==========================================================
  // command byte layout
  localparam int CMD_DIR_BIT   = 7;
  localparam int ADDR_W        = 7;
  localparam int DATA_W        = 8;
  localparam int BIT_CNT_W     = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // ==========================================================
  // address map
  localparam logic [6:0] ADDR_FIRST    = 7'h00;
  localparam logic [6:0] ADDR_LAST_REG = 7'h0D;
  localparam logic [6:0] ADDR_CONTROL  = 7'h0B;
  localparam int CTRL_WP_BIT = 6;
  // ==========================================================
  // host link clock divider: half period in clk_sys cycles
  localparam int SYS_PERIOD_NS   = 4;
  localparam int LINK_PERIOD_NS  = 128;
  localparam int HALF_DIV        = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam logic [5:0] HALF_DIV_M1 = 6'(HALF_DIV - 1);

  function automatic logic [6:0] next_addr(input logic [6:0] a);
    if (a == ADDR_LAST_REG) begin
      return ADDR_FIRST;
    end
    return a + 7'h01;
  endfunction

  function automatic logic reg_reserved(input logic [6:0] a);
    return a > ADDR_LAST_REG;
  endfunction
endpackage

/* File: tw_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface tw_link_if;
  logic sel;
  logic sclk;
  logic host_dq_o;
  logic host_dq_oe;
  logic dev_dq_o;
  logic dev_dq_oe;
  logic dq;
  assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : 1'b1);
  modport host (output sel, output sclk, output host_dq_o, output host_dq_oe, input dq);
  modport dev  (input sel, input sclk, output dev_dq_o, output dev_dq_oe, input dq);
endinterface
`default_nettype wire

/* File: tw_host_port.sv */
`timescale 1ns/1ns
`default_nettype none
module tw_host_port
  import tw_pkg::*;
(
  tw_link_if.host         link,
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic       req_write,
  input  wire logic [6:0] req_addr,
  input  wire logic [3:0] req_count,
  input  wire logic [7:0] wr_data,
  output logic            wr_data_take,
  output logic [7:0]      rd_data,
  output logic            rd_valid
);
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_END} host_state_t;
  host_state_t state_reg;
  logic [5:0] div_reg;
  logic       sclk_reg;
  logic       sel_reg;
  logic [2:0] bit_reg;
  logic [3:0] left_reg;
  logic       wr_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic       dq_s1_reg;
  logic       dq_s2_reg;
  logic       take_reg;
  logic       rdv_reg;
  logic [7:0] rdd_reg;
  logic       tick;
  assign tick = div_reg == HALF_DIV_M1;

  // ==========================================================
  // data line synchroniser
  always_ff @(posedge clk_sys) begin
    dq_s1_reg <= link.dq;
    dq_s2_reg <= dq_s1_reg;
  end

  // ==========================================================
  // sequencer, link clock divided from clk_sys
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      div_reg   <= 6'h00;
      sclk_reg  <= 1'b0;
      sel_reg   <= 1'b0;
      bit_reg   <= 3'h0;
      left_reg  <= 4'h0;
      wr_reg    <= 1'b0;
      tx_reg    <= 8'h00;
      rx_reg    <= 8'h00;
      take_reg  <= 1'b0;
      rdv_reg   <= 1'b0;
      rdd_reg   <= 8'h00;
    end else begin
      take_reg <= 1'b0;
      rdv_reg  <= 1'b0;
      div_reg  <= tick ? 6'h00 : div_reg + 6'h01;
      case (state_reg)
        ST_IDLE: begin
          sclk_reg <= 1'b0;
          if (req_valid && req_count != 4'h0) begin
            state_reg <= ST_CMD;
            sel_reg   <= 1'b1;
            wr_reg    <= req_write;
            left_reg  <= req_count;
            tx_reg    <= {req_write, req_addr};
            bit_reg   <= 3'h0;
            div_reg   <= 6'h00;
          end
        end
        ST_CMD, ST_DATA: begin
          if (tick) begin
            sclk_reg <= ~sclk_reg;
            if (!sclk_reg) begin
              // rising edge next: device samples, we capture its bit too
              rx_reg <= {dq_s2_reg, rx_reg[7:1]};
            end else begin
              tx_reg  <= {1'b0, tx_reg[7:1]};
              bit_reg <= bit_reg + 3'h1;
              if (bit_reg == LAST_BIT) begin
                if (state_reg == ST_CMD) begin
                  state_reg <= ST_DATA;
                end else begin
                  rdd_reg  <= rx_reg;
                  rdv_reg  <= ~wr_reg;
                  left_reg <= left_reg - 4'h1;
                  if (left_reg == 4'h1) begin
                    state_reg <= ST_END;
                  end
                end
                if (wr_reg && !(state_reg == ST_DATA && left_reg == 4'h1)) begin
                  tx_reg   <= wr_data;
                  take_reg <= 1'b1;
                end
              end
            end
          end
        end
        ST_END: begin
          if (tick) begin
            sel_reg   <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign link.sel        = sel_reg;
  assign link.sclk       = sclk_reg;
  assign link.host_dq_o  = tx_reg[0];
  assign link.host_dq_oe = sel_reg && (state_reg == ST_CMD || wr_reg);
  assign req_ready       = state_reg == ST_IDLE;
  assign wr_data_take    = take_reg;
  assign rd_data         = rdd_reg;
  assign rd_valid        = rdv_reg;
endmodule
`default_nettype wire

/* File: tw_link_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module tw_link_monitor (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sel,
  input wire logic sclk,
  input wire logic host_dq_o,
  input wire logic host_dq_oe,
  input wire logic dev_dq_o,
  input wire logic dev_dq_oe,
  input wire logic dq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========
  // rise count
  logic       sclk_q;
  logic [7:0] rises;
  logic       wr_cmd;
  always_ff @(posedge clk_sys) sclk_q <= sclk;
  always_ff @(posedge clk_sys) begin
    if (!sel) rises <= 8'h00;
    else if (sclk && !sclk_q) rises <= rises + 8'h01;
  end
  always_ff @(posedge clk_sys) if (sclk && !sclk_q && rises == 8'h07) wr_cmd <= dq;
  // ==========
  // properties
  sequence s_hold; $stable(host_dq_o) ##1 $stable(host_dq_o); endsequence
  property p_release; !sel |-> !dev_dq_oe; endproperty
  property p_fall; dev_dq_oe && $past(dev_dq_oe) && $changed(dev_dq_o) |-> $fell(sclk); endproperty
  property p_host_hold; host_dq_oe && $rose(sclk) |-> s_hold; endproperty
  property p_no_clash; !(host_dq_oe && dev_dq_oe); endproperty
  property p_idle_clk; !sel |-> !sclk; endproperty
  property p_end_cycle; $fell(sel) |-> !$past(sclk); endproperty
  property p_first; $rose(dev_dq_oe) |-> $fell(sclk) && rises == 8'h08; endproperty
  property p_cmd_quiet; sel && rises < 8'h08 |-> !dev_dq_oe; endproperty
  property p_wr_quiet; sel && wr_cmd && rises > 8'h07 |-> !dev_dq_oe; endproperty
  property p_rd_drive; sel && !wr_cmd && rises > 8'h08 |-> dev_dq_oe; endproperty
  a_release: assert property (p_release) else $error("line driven unselected");
  a_fall: assert property (p_fall) else $error("read bit moved off falling edge");
  a_host_hold: assert property (p_host_hold) else $error("host data moved at rise");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive");
  a_idle_clk: assert property (p_idle_clk) else $error("clock high while idle");
  a_end_cycle: assert property (p_end_cycle) else $error("select fell mid cycle");
  a_first: assert property (p_first) else $error("read drive start wrong");
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("drive during command");
  a_wr_quiet: assert property (p_wr_quiet) else $error("drive during write");
  a_rd_drive: assert property (p_rd_drive) else $error("no drive during read");
endmodule
`default_nettype wire

/* File: test_three_wire_register_port.sv */
`timescale 1ns/1ns
`default_nettype none
module test_three_wire_register_port import tw_pkg::*;;
  logic       clk_sys, reset_n, req_valid, req_ready, req_write, wr_data_take, rd_valid;
  logic       reg_rd_stb, reg_wr_stb, wp_bit;
  logic [6:0] req_addr, reg_addr;
  logic [3:0] req_count;
  logic [7:0] wr_data, rd_data, reg_wr_data, reg_rd_data, cmd_sh;
  logic [7:0] got_q[$];
  logic [7:0] exp_q[$];
  logic [7:0] ga_q[$];
  logic [7:0] ea_q[$];
  int         rd_stbs;
  int         failures, comparisons, widx, nbits;
  tw_link_if link ();
  tw_host_port tw_host_port_inst (.link(link), .clk_sys(clk_sys), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_count(req_count), .wr_data(wr_data), .wr_data_take(wr_data_take), .rd_data(rd_data),
    .rd_valid(rd_valid));
  tw_device_port tw_device_port_inst (.link(link), .clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_rd_stb(reg_rd_stb), .reg_wr_stb(reg_wr_stb),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .wp_bit(wp_bit));
  tw_link_monitor monitor_inst (.clk_sys(clk_sys), .reset_n(reset_n), .sel(link.sel),
    .sclk(link.sclk), .host_dq_o(link.host_dq_o), .host_dq_oe(link.host_dq_oe),
    .dev_dq_o(link.dev_dq_o), .dev_dq_oe(link.dev_dq_oe), .dq(link.dq));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ==========
  // register file and capture
  function automatic logic [7:0] pat(input logic [6:0] a); return 8'h96 ^ {1'b0, a}; endfunction
  function automatic logic [7:0] wd(input int i); return 8'(8'h3C + i * 8'h11); endfunction
  always @(posedge clk_sys) begin
    reg_rd_data <= pat(reg_addr);
    if (wr_data_take === 1'b1) begin
      widx <= widx + 1;
      wr_data <= wd(widx + 1);
    end
    if (rd_valid === 1'b1) got_q.push_back(rd_data);
    if (reg_wr_stb === 1'b1) begin
      got_q.push_back(reg_wr_data);
      ga_q.push_back({1'b0, reg_addr});
    end
    if (reg_rd_stb === 1'b1) rd_stbs <= rd_stbs + 1;
  end
  always @(posedge link.sclk) if (link.sel === 1'b1 && nbits < 8) begin
    cmd_sh <= {link.dq, cmd_sh[7:1]};
    nbits <= nbits + 1;
  end
  // ==========
  // checks
  task cmp8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task run(input logic w, input logic [6:0] a, input logic [3:0] n, input logic wp,
           input string name);
    int         t;
    logic [6:0] p;
    exp_q.delete();
    ea_q.delete();
    p = a;
    for (int j = 0; j < n; j++) begin
      if (p > ADDR_LAST_REG) begin
        if (!w) exp_q.push_back(8'h00);
      end else if (!w) exp_q.push_back(pat(p));
      else if (!wp) begin
        exp_q.push_back(wd(j));
        ea_q.push_back({1'b0, p});
      end
      p = (p == ADDR_LAST_REG) ? 7'h00 : p + 7'h01;
    end
    got_q.delete();
    ga_q.delete();
    rd_stbs = 0;
    nbits = 0;
    @(posedge clk_sys);
    wp_bit <= wp;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_count <= n;
    wr_data <= wd(0);
    widx <= 0;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    t = 0;
    do begin
      @(negedge clk_sys);
      t++;
    end while (req_ready !== 1'b1 && t < 9000);
    if (t >= 9000) begin
      failures++;
      $display("[FAIL] %0t timeout waiting for idle", $time);
      close_out();
    end
    repeat (40) @(posedge clk_sys);
    cmp8(cmd_sh, {w, a});
    cmp8(8'(got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) cmp8(got_q[i], exp_q[i]);
    cmp8(8'(ga_q.size()), 8'(ea_q.size()));
    foreach (ea_q[i]) if (i < ga_q.size()) cmp8(ga_q[i], ea_q[i]);
    cmp8(8'(rd_stbs), w ? 8'h00 : 8'(n) + 8'h01);
    $display("test %s done", name);
  endtask
  initial begin
    reset_n = 1'b0;
    {req_valid, req_write, wp_bit, req_addr, req_count, wr_data, reg_rd_data} = '0;
    {failures, comparisons, widx, nbits} = '0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    run(1'b0, 7'h0C, 4'h4, 1'b0, "burst_read_wrap");
    run(1'b0, 7'h05, 4'h1, 1'b0, "single_read");
    run(1'b0, 7'h7E, 4'h2, 1'b0, "reserved_read");
    run(1'b1, 7'h0D, 4'h2, 1'b0, "write_wrap");
    run(1'b1, 7'h03, 4'h3, 1'b1, "write_protect");
    run(1'b1, 7'h0E, 4'h1, 1'b0, "reserved_write");
    run(1'b0, 7'h00, 4'hF, 1'b0, "long_burst");
    close_out();
  end
endmodule
`default_nettype wire
